// ===== src/pbe_pkg.sv
package pbe_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PORT_B_DATA_DATA   = 8'h06;
  localparam logic [7:0] IDX_PORT_B_DATA_DIR    = 8'h86;
  localparam logic [7:0] IDX_OPTION       = 8'h81;
  localparam logic [7:0] IDX_INTERRUPT_CONTROL_REGISTER       = 8'h0b;
  localparam logic [7:0] IDX_CTRL_PINS    = 8'h09;
  localparam logic [7:0] IDX_CTRL_DIR     = 8'h89;
  localparam logic [7:0] IDX_SLAVE_DATA   = 8'h08;
  localparam logic [7:0] IDX_WAKE         = 8'h0c;
  // field positions
  localparam int POS_PULLUP_DISABLE = 7;
  localparam int POS_CHANGE_FLAG    = 0;
  localparam int POS_INPUT_FULL     = 7;
  localparam int POS_OUTPUT_FULL    = 6;
  localparam int POS_INPUT_OVERFLOW = 5;
  localparam int POS_SLAVE_MODE     = 4;
  localparam int POS_CS_DIR         = 2;
  localparam int POS_WR_DIR         = 1;
  localparam int POS_RD_DIR         = 0;
  localparam int POS_SLEEP          = 0;
  // reset values and masks
  localparam logic [7:0] RST_PORT_B_DATA_DIR  = 8'hff;
  localparam logic [7:0] RST_OPTION     = 8'hff;
  localparam logic [7:0] RST_CTRL_DIR   = 8'h07;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] CTRL_DIR_WMASK = 8'h17;
  localparam logic [3:0] WATCH_MASK     = 4'hf;
  localparam logic [2:0] CTRL_PIN_MASK  = 3'h7;
endpackage

// ===== src/pbe_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pbe_if;
  logic [7:0] pb_i;
  logic [7:0] pb_o;
  logic [7:0] pb_oe;
  logic [7:0] pb_pu;
  logic [2:0] pe_i;
  logic [2:0] pe_o;
  logic [2:0] pe_oe;
  logic [7:0] pd_i;
  logic [7:0] pd_o;
  logic [7:0] pd_oe;
  modport dev (
    input  pb_i, pe_i, pd_i,
    output pb_o, pb_oe, pb_pu, pe_o, pe_oe, pd_o, pd_oe
  );
  modport host (
    input  pd_o, pd_oe, pe_o, pe_oe,
    output pe_i, pd_i
  );
endinterface
`default_nettype wire

// ===== src/pbe_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pbe_sync #(
  parameter int W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pbe_sync_t;
  pbe_sync_t r;
  pbe_sync_t next_r;
  always_comb begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end
  // reset value is a constant at each instance
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      r <= {rst_val, rst_val};
    end else if (ce) begin
      r <= next_r;
    end
  end
  assign q = r.s2;
endmodule // pbe_sync
`default_nettype wire

// ===== src/pbe_dev.sv
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module pbe_dev
  import pbe_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             wake,
  pbe_if.dev               pins
);
  typedef struct packed {
    logic [7:0]  pb_lat;
    logic [7:0]  pb_dir;
    logic [7:0]  option;
    logic        change_flag;
    logic [3:0]  cmp_lat;
    logic [2:0]  pe_lat;
    logic [7:0]  pe_dir;
    logic [7:0]  pd_lat;
    logic [7:0]  pd_in;
    logic        sleep;
    logic        wr_prev;
    logic        rd_prev;
    logic        ack;
    logic [31:0] rdata;
  } pbe_dev_t;
  pbe_dev_t r;
  pbe_dev_t next_r;

  logic [7:0] pb_s;
  logic [2:0] pe_s;
  logic [7:0] pd_s;
  pbe_sync #(.W(8)) u_sb (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .ce      (ce),
    .d       (pins.pb_i),
    .rst_val (RST_ZERO),
    .q       (pb_s)
  );
  // strobes reset to idle high so no false host access after reset
  pbe_sync #(.W(3)) u_se (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .ce      (ce),
    .d       (pins.pe_i),
    .rst_val (CTRL_PIN_MASK),
    .q       (pe_s)
  );
  pbe_sync #(.W(8)) u_sd (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .ce      (ce),
    .d       (pins.pd_i),
    .rst_val (RST_ZERO),
    .q       (pd_s)
  );

  logic       acc;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] idx;
  logic [7:0] wd;
  logic       mode;
  logic       host_rd;
  logic       host_wr;
  logic [3:0] mismatch;

  always_comb begin
    acc      = cyc_i && stb_i && !r.ack;
    wr_en    = acc && we_i && sel_i[0];
    rd_en    = acc && !we_i;
    idx      = adr_i[9:2];
    wd       = dat_i[7:0];
    mode     = r.pe_dir[POS_SLAVE_MODE];
    // unsynchronised strobes would glitch; use synced levels
    host_rd  = mode && !pe_s[2] && !pe_s[0];
    host_wr  = mode && !pe_s[2] && !pe_s[1];
    mismatch = (pb_s[7:4] ^ r.cmp_lat) & r.pb_dir[7:4] & WATCH_MASK;
    next_r         = r;
    next_r.ack     = acc;
    next_r.rdata   = '0;
    next_r.wr_prev = host_wr;
    next_r.rd_prev = host_rd;
    if (|mismatch) begin
      next_r.change_flag = 1'b1;
      next_r.sleep       = 1'b0;
    end
    // host write ends: capture word
    if (r.wr_prev && !host_wr) begin
      next_r.pd_in = pd_s;
      if (r.pe_dir[POS_INPUT_FULL]) begin
        next_r.pe_dir[POS_INPUT_OVERFLOW] = 1'b1;
      end
      next_r.pe_dir[POS_INPUT_FULL] = 1'b1;
    end
    if (r.rd_prev && !host_rd) begin
      next_r.pe_dir[POS_OUTPUT_FULL] = 1'b0;
    end
    if (rd_en) begin
      unique case (idx)
        IDX_PORT_B_DATA_DATA: begin
          next_r.rdata   = {24'h00_0000, pb_s};
          next_r.cmp_lat = pb_s[7:4];
        end
        IDX_PORT_B_DATA_DIR:  next_r.rdata = {24'h00_0000, r.pb_dir};
        IDX_OPTION:     next_r.rdata = {24'h00_0000, r.option};
        IDX_INTERRUPT_CONTROL_REGISTER:     next_r.rdata = {31'h0000_0000, r.change_flag};
        IDX_CTRL_PINS:  next_r.rdata = {29'h0000_0000, pe_s};
        IDX_CTRL_DIR:   next_r.rdata = {24'h00_0000, r.pe_dir};
        IDX_SLAVE_DATA: begin
          next_r.rdata = {24'h00_0000, r.pd_in};
          if (!(r.wr_prev && !host_wr)) begin
            next_r.pe_dir[POS_INPUT_FULL] = 1'b0;
          end
        end
        IDX_WAKE:       next_r.rdata = {31'h0000_0000, r.sleep};
        default:        next_r.rdata = '0;
      endcase
    end
    if (wr_en) begin
      unique case (idx)
        IDX_PORT_B_DATA_DATA: begin
          // written byte stored to latch unchanged; the pin-merged value is overwritten
          next_r.pb_lat  = (pb_s & r.pb_dir) | (wd & ~r.pb_dir);
          next_r.pb_lat  = wd;
          next_r.cmp_lat = pb_s[7:4];
        end
        IDX_PORT_B_DATA_DIR:  next_r.pb_dir = wd;
        IDX_OPTION:     next_r.option = wd;
        IDX_INTERRUPT_CONTROL_REGISTER: begin
          // a live mismatch re-sets the flag in the same cycle
          if (!wd[POS_CHANGE_FLAG] && !(|mismatch)) begin
            next_r.change_flag = 1'b0;
          end
        end
        IDX_CTRL_PINS:  next_r.pe_lat = wd[2:0];
        IDX_CTRL_DIR: begin
          // built on next_r so a status set in this cycle is not lost
          next_r.pe_dir = (next_r.pe_dir & ~CTRL_DIR_WMASK) | (wd & CTRL_DIR_WMASK);
          // overflow clears only by writing zero; a new overflow wins
          next_r.pe_dir[POS_INPUT_OVERFLOW] = (r.pe_dir[POS_INPUT_OVERFLOW] &
            wd[POS_INPUT_OVERFLOW]) | (r.wr_prev && !host_wr && r.pe_dir[POS_INPUT_FULL]);
        end
        IDX_SLAVE_DATA: begin
          next_r.pd_lat = wd;
          next_r.pe_dir[POS_OUTPUT_FULL] = 1'b1;
        end
        IDX_WAKE:       next_r.sleep = wd[POS_SLEEP];
        default:        next_r.sleep = r.sleep;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      r        <= '0;
      r.pb_dir <= RST_PORT_B_DATA_DIR;
      r.option <= RST_OPTION;
      r.pe_dir <= RST_CTRL_DIR;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign dat_o      = r.rdata;
  assign ack_o      = r.ack;
  assign wake       = !r.sleep;
  assign pins.pb_o  = r.pb_lat;
  assign pins.pb_oe = ~r.pb_dir;
  // pull-ups only on inputs, and only with the enable bit low
  assign pins.pb_pu = r.option[POS_PULLUP_DISABLE] ? 8'h00 : r.pb_dir;
  assign pins.pe_o  = r.pe_lat;
  // slave mode forces the control pins to inputs regardless of direction
  assign pins.pe_oe = mode ? 3'h0 : ~r.pe_dir[2:0];
  assign pins.pd_o  = r.pd_lat;
  assign pins.pd_oe = {8{host_rd}};
endmodule // pbe_dev
`default_nettype wire

// ===== src/pbe_host.sv
// host processor end of the slave data port
`timescale 1ns/1ns
`default_nettype none
module pbe_host
  import pbe_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       req,
  input  wire logic       req_we,
  input  wire logic [7:0] req_data,
  output logic            busy,
  output logic            done,
  output logic [7:0]      rd_data,
  pbe_if.host             pins
);
  typedef enum logic [1:0] {HS_IDLE, HS_STROBE, HS_HOLD, HS_DONE} pbe_hs_t;
  typedef struct packed {
    pbe_hs_t    st;
    logic       we;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [2:0] cnt;
  } pbe_host_t;
  pbe_host_t r;
  pbe_host_t next_r;
  logic [7:0] pd_s;
  logic [7:0] pd_bus;
  // undriven bus reads as the inverse so a missing drive is seen
  assign pd_bus = (pins.pd_o & pins.pd_oe) | (~pins.pd_o & ~pins.pd_oe);
  pbe_sync #(.W(8)) u_sd (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .d(pd_bus),
    .rst_val(RST_ZERO), .q(pd_s));

  always_comb begin
    next_r = r;
    unique case (r.st)
      HS_IDLE: if (req) begin
        next_r.st    = HS_STROBE;
        next_r.we    = req_we;
        next_r.wdata = req_data;
        next_r.cnt   = '0;
      end
      // strobe held long enough for the device's two-stage sync
      HS_STROBE: begin
        next_r.cnt = r.cnt + 3'd1;
        if (r.cnt == 3'd5) begin
          next_r.rdata = pd_s;
          next_r.st    = HS_HOLD;
          next_r.cnt   = '0;
        end
      end
      HS_HOLD: begin
        next_r.cnt = r.cnt + 3'd1;
        if (r.cnt == 3'd3) begin
          next_r.st = HS_DONE;
        end
      end
      HS_DONE: next_r.st = HS_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end
  logic act;
  assign act        = (r.st == HS_STROBE);
  assign pins.pe_i  = {!act, !(act && r.we), !(act && !r.we)};
  assign pins.pd_i  = r.wdata;
  assign busy       = (r.st != HS_IDLE);
  assign done       = (r.st == HS_DONE);
  assign rd_data    = r.rdata;
endmodule // pbe_host
`default_nettype wire

// ===== testbench/pbe_checker.sv
`timescale 1ns/1ns
`default_nettype none
module pbe_checker
  import pbe_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [7:0]  pb_i,
  input wire logic [7:0]  pb_oe,
  input wire logic [7:0]  pb_pu,
  input wire logic [2:0]  pe_i,
  input wire logic [2:0]  pe_oe,
  input wire logic [7:0]  pd_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire logic wr;
  assign wr = ack_o && we_i && sel_i[0];
  property p_pu_out_off;
    (pb_pu & pb_oe) == 8'h00;
  endproperty
  a_pu_out_off: assert property (p_pu_out_off) else $error("pull-up on driven pin");
  property p_pu_reset;
    $rose(nrst) |-> pb_pu == 8'h00;
  endproperty
  a_pu_reset: assert property (p_pu_reset) else $error("pull-up on after reset");
  // pins pass a synchroniser, so only a settled level is compared
  property p_read;
    $stable(pb_i)[*5] ##0 (ack_o && !we_i && adr_i == 32'h0000_0018) |-> dat_o[7:0] == pb_i;
  endproperty
  a_read: assert property (p_read) else $error("port read not pin level");
  property p_cs_idle;
    pe_i[2][*5] |-> pd_oe == 8'h00;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("data driven while unselected");
  property p_pd_whole;
    pd_oe != 8'h00 |-> pd_oe == 8'hff && pe_oe == 3'h0;
  endproperty
  a_pd_whole: assert property (p_pd_whole) else $error("partial data drive");
  property p_pb_dir;
    wr && adr_i == 32'h0000_0218 |=> ##1 pb_oe == ~$past(dat_i[7:0], 2);
  endproperty
  a_pb_dir: assert property (p_pb_dir) else $error("port enable not direction");
  property p_pe_dir;
    wr && adr_i == 32'h0000_0224 && !dat_i[4] |=> ##1 pe_oe == ~$past(dat_i[2:0], 2);
  endproperty
  a_pe_dir: assert property (p_pe_dir) else $error("control enable wrong");
  property p_slave_in;
    wr && adr_i == 32'h0000_0224 && dat_i[4] |=> ##1 pe_oe == 3'h0;
  endproperty
  a_slave_in: assert property (p_slave_in) else $error("control pin driven in slave");
  c_slave: cover property (wr && adr_i == 32'h0000_0224 && dat_i[4]);
  c_host_rd: cover property (pd_oe == 8'hff);
  c_read: cover property (ack_o && !we_i && adr_i == 32'h0000_0018);
endmodule // pbe_checker
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
  import pbe_pkg::*;
;
  logic        ref_clk, nrst, cyc, stb, we, ack, req, req_we, busy, done, wake;
  logic [31:0] adr, dat, dat_o;
  logic [3:0]  sel;
  logic [7:0]  req_data, rd_data, ext, q;
  int          bad_count = 0;
  int          checked = 0;
  pbe_if ifc ();
  // pin level: driver wins, else the outside level
  assign ifc.pb_i = (ifc.pb_oe & ifc.pb_o) | (~ifc.pb_oe & ext);
  pbe_dev pbe_dev_inst (.ref_clk(ref_clk), .nrst(nrst), .ce(1'b1), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack),
    .wake(wake), .pins(ifc.dev));
  pbe_host pbe_host_inst (.ref_clk(ref_clk), .nrst(nrst), .ce(1'b1), .req(req),
    .req_we(req_we), .req_data(req_data), .busy(busy), .done(done), .rd_data(rd_data),
    .pins(ifc.host));
  pbe_checker pbe_checker_inst (.ref_clk(ref_clk), .nrst(nrst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack),
    .pb_i(ifc.pb_i), .pb_oe(ifc.pb_oe), .pb_pu(ifc.pb_pu), .pe_i(ifc.pe_i),
    .pe_oe(ifc.pe_oe), .pd_oe(ifc.pd_oe));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {22'h0, i, 2'h0};
    dat <= {24'h0, d};
    @(posedge ref_clk);
    while (ack !== 1'b1) @(posedge ref_clk);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    wb(1'b0, i, 8'h00);
    chk(q, e);
  endtask
  task automatic flag(input logic e);
    wb(1'b0, IDX_INTERRUPT_CONTROL_REGISTER, 8'h00);
    chk({7'h0, q[POS_CHANGE_FLAG]}, {7'h0, e});
  endtask
  task automatic hx(input logic w, input logic [7:0] d);
    req <= 1'b1;
    req_we <= w;
    req_data <= d;
    @(posedge ref_clk);
    req <= 1'b0;
    @(posedge ref_clk);
    chk({7'h0, busy}, 8'h01);
    while (done !== 1'b1) @(posedge ref_clk);
    @(posedge ref_clk);
  endtask
  task automatic results();
    if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge ref_clk);
    bad_count++;
    results();
  end
  initial begin
    nrst = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 32'h0000_0000;
    dat = 32'h0000_0000;
    sel = 4'hf;
    req = 1'b0;
    req_we = 1'b0;
    req_data = 8'h00;
    ext = 8'h5a;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk(ifc.pb_pu, 8'h00);
    rc(IDX_CTRL_DIR, 8'h07);
    wb(1'b1, IDX_OPTION, 8'h7f);
    chk(ifc.pb_pu, 8'hff);
    wb(1'b1, IDX_PORT_B_DATA_DIR, 8'h0f);
    wb(1'b1, IDX_PORT_B_DATA_DATA, 8'ha5);
    chk(ifc.pb_oe, 8'hf0);
    chk(ifc.pb_pu, 8'h0f);
    repeat (4) @(posedge ref_clk);
    rc(IDX_PORT_B_DATA_DATA, 8'haa);
    // upper nibble becomes watched inputs
    wb(1'b1, IDX_PORT_B_DATA_DIR, 8'hf0);
    repeat (4) @(posedge ref_clk);
    rc(IDX_PORT_B_DATA_DATA, 8'h55);
    wb(1'b1, IDX_INTERRUPT_CONTROL_REGISTER, 8'h00);
    flag(1'b0);
    wb(1'b1, IDX_WAKE, 8'h01);
    chk({7'h0, wake}, 8'h00);
    ext <= 8'h7a;
    repeat (4) @(posedge ref_clk);
    chk({7'h0, wake}, 8'h01);
    flag(1'b1);
    wb(1'b1, IDX_INTERRUPT_CONTROL_REGISTER, 8'h00);
    flag(1'b1);
    wb(1'b0, IDX_PORT_B_DATA_DATA, 8'h00);
    wb(1'b1, IDX_INTERRUPT_CONTROL_REGISTER, 8'h00);
    flag(1'b0);
    // upper pins driven: outside changes must not flag
    wb(1'b1, IDX_PORT_B_DATA_DIR, 8'h0f);
    repeat (4) @(posedge ref_clk);
    wb(1'b0, IDX_PORT_B_DATA_DATA, 8'h00);
    wb(1'b1, IDX_INTERRUPT_CONTROL_REGISTER, 8'h00);
    ext <= 8'h05;
    // driven upper pins change against the compare latch: no flag allowed
    wb(1'b1, IDX_PORT_B_DATA_DATA, 8'h5a);
    repeat (4) @(posedge ref_clk);
    flag(1'b0);
    wb(1'b1, IDX_CTRL_DIR, 8'h05);
    chk({5'h0, ifc.pe_oe}, 8'h02);
    wb(1'b1, IDX_CTRL_DIR, 8'h17);
    chk({5'h0, ifc.pe_oe}, 8'h00);
    hx(1'b1, 8'h3c);
    rc(IDX_CTRL_DIR, 8'h97);
    rc(IDX_SLAVE_DATA, 8'h3c);
    rc(IDX_CTRL_DIR, 8'h17);
    hx(1'b1, 8'h11);
    hx(1'b1, 8'h22);
    rc(IDX_CTRL_DIR, 8'hb7);
    wb(1'b1, IDX_CTRL_DIR, 8'h17);
    wb(1'b0, IDX_SLAVE_DATA, 8'h00);
    rc(IDX_CTRL_DIR, 8'h17);
    wb(1'b1, IDX_SLAVE_DATA, 8'h69);
    rc(IDX_CTRL_DIR, 8'h57);
    hx(1'b0, 8'h00);
    chk(rd_data, 8'h69);
    rc(IDX_CTRL_DIR, 8'h17);
    wb(1'b1, 8'h7f, 8'hff);
    rc(8'h7f, 8'h00);
    results();
  end
endmodule // tb
`default_nettype wire
